/* hw/fall_counter.sv */
module fall_counter
  import frame_check_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic fall,
  input wire logic cs_high,
  input wire logic clr,
  input wire logic win,
  input wire pkt_mode_t pkt_mode,
  output logic [CNT_W-1:0] cnt
);

  logic count_en;

  // ==========================================================
  // Which falling edges count
  always_comb begin
    count_en = 1'b0;
    if (fall) begin
      if (!cs_high) begin
        count_en = 1'b1;
      end else begin
        case (pkt_mode)
          PKT_16, PKT_17: count_en = 1'b1;
          PKT_20: count_en = win;
          PKT_21: count_en = 1'b0;
          default: count_en = 1'b0;
        endcase
      end
    end
  end

  // Cleared at frame end; an edge in that very cycle opens the next count, except in 21-bit mode where it is dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= count_en ? CNT_W'(1) : '0;
    end else if (count_en && cnt != CNT_MAX) begin
      cnt <= cnt + CNT_W'(1);
    end
  end

endmodule

/* hw/spi_frame_error_detector.sv */
module spi_frame_error_detector
  import frame_check_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire pkt_mode_t pkt_mode,
  input wire logic [7:0] nvm_cfg_1b,
  input wire logic crc_check_en,
  input wire logic crc_mismatch,
  input wire logic manch_frame_err,
  input wire logic clear_warn,
  input wire logic [WARN_OTHER_W-1:0] other_warn,
  output logic miso,
  output logic miso_oe,
  output logic wr_valid,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [15:0] warning_flags
);

  // ==========================================================
  // Pin synchronisation and edge detection
  logic [2:0] pins_s;
  logic sclk_s, cs_s, mosi_s;
  logic sclk_prev_q, cs_prev_q;
  logic fall, rise, cs_rise, cs_fall;

  sync2 #(.WIDTH(3), .INIT(3'h6)) u_sync (
    .clk(mclk),
    .srst(srst),
    .d({sclk, cs_n, mosi}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign mosi_s = pins_s[0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
    end
  end

  assign fall = sclk_prev_q & ~sclk_s;
  assign rise = ~sclk_prev_q & sclk_s;
  assign cs_rise = ~cs_prev_q & cs_s;
  assign cs_fall = cs_prev_q & ~cs_s;

  // ==========================================================
  // Configuration and edge count
  state_t state_q;
  logic [3:0] hold_q;
  logic s17;
  logic [4:0] len;
  logic win;
  logic [CNT_W-1:0] edge_cnt;
  logic len_bad;

  assign s17 = nvm_cfg_1b[S17_BIT];
  assign win = cs_rise | (state_q == ST_HOLD);

  always_comb begin
    case (pkt_mode)
      PKT_16: len = LEN_16;
      PKT_17: len = LEN_17;
      PKT_20: len = LEN_20;
      PKT_21: len = LEN_21;
      default: len = LEN_16;
    endcase
  end

  fall_counter u_cnt (
    .clk(mclk),
    .srst(srst),
    .fall(fall),
    .cs_high(cs_s),
    .clr(cs_rise),
    .win(win),
    .pkt_mode(pkt_mode),
    .cnt(edge_cnt)
  );

  // count must match the packet length
  always_comb begin
    case (pkt_mode)
      // select set tolerates one extra edge
      PKT_16: len_bad = !(edge_cnt == CNT_W'(LEN_16) || (s17 && edge_cnt == CNT_W'(LEN_17)));
      PKT_17: len_bad = !(s17 && edge_cnt == CNT_W'(LEN_17));
      PKT_20: len_bad = edge_cnt != CNT_W'(LEN_20);
      PKT_21: len_bad = edge_cnt != CNT_W'(LEN_21);
      default: len_bad = 1'b1;
    endcase
  end

  // ==========================================================
  // Frame sequencing
  logic frame_end, commit, stray, discard_q, pend_ok_q;

  assign frame_end = cs_rise & (state_q == ST_FRAME);
  assign commit = (state_q == ST_HOLD) & ((hold_q == 4'h0) | cs_fall);
  assign stray = discard_q | fall;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      hold_q <= 4'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (cs_rise) begin
            state_q <= ST_HOLD;
            hold_q <= HOLD_LOAD;
          end
        end
        ST_HOLD: begin
          if (commit) begin
            state_q <= cs_fall ? ST_FRAME : ST_IDLE;
          end else begin
            hold_q <= hold_q - 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // any falling clock edge inside the window drops the frame
  always_ff @(posedge mclk) begin
    if (srst) begin
      discard_q <= 1'b0;
    end else if (frame_end) begin
      discard_q <= fall;
    end else if (state_q == ST_HOLD && fall) begin
      discard_q <= 1'b1;
    end
  end

  // ==========================================================
  // Receive shifter, MOSI sampled on rising clock
  logic [RX_W-1:0] rx_q, aligned;
  logic [4:0] rx_cnt_q;
  logic first_q;
  logic is_read;
  logic [5:0] addr;

  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_q <= '0;
      rx_cnt_q <= 5'h0;
      first_q <= 1'b0;
    end else if (cs_fall) begin
      rx_q <= '0;
      rx_cnt_q <= 5'h0;
      first_q <= 1'b0;
    end else if (state_q == ST_FRAME && !cs_s && rise) begin
      rx_q <= {rx_q[RX_W-2:0], mosi_s};
      if (rx_cnt_q != RX_LEN) begin
        rx_cnt_q <= rx_cnt_q + 5'h1;
      end
      if (rx_cnt_q == 5'h0) begin
        first_q <= mosi_s;
      end
    end
  end

  // Short frames and frames led by a one are never acted upon
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_ok_q <= 1'b0;
    end else if (frame_end) begin
      pend_ok_q <= !first_q && rx_cnt_q == len;
    end
  end

  assign aligned = rx_q << (RX_LEN - len);
  assign is_read = aligned[RW_POS] == RW_READ;
  assign addr = aligned[ADDR_HI:ADDR_LO];

  // ==========================================================
  // Warning flags
  logic frame_err_q, crc_err_q, frame_set, crc_set;
  logic [15:0] warn_q;

  assign frame_set = (frame_end & (len_bad | first_q)) | manch_frame_err;
  // checksum only carried by 20/21-bit frames
  assign crc_set = frame_end & crc_check_en & crc_mismatch
                   & (pkt_mode == PKT_20 || pkt_mode == PKT_21);

  // set wins over a simultaneous clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      frame_err_q <= 1'b0;
    end else if (frame_set) begin
      frame_err_q <= 1'b1;
    end else if (clear_warn) begin
      frame_err_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      crc_err_q <= 1'b0;
    end else if (crc_set) begin
      crc_err_q <= 1'b1;
    end else if (clear_warn) begin
      crc_err_q <= 1'b0;
    end
  end

  // flag at bit 11 of the word at 0x26/0x27
  // fixed nibble, zero bit, other warnings
  always_ff @(posedge mclk) begin
    if (srst) begin
      warn_q <= WARN_RESET;
    end else begin
      warn_q <= {WARN_FIXED, frame_err_q, crc_err_q, 1'b0, other_warn};
    end
  end

  assign warning_flags = warn_q;

  // ==========================================================
  // Response path; answer goes out in the following frame
  logic [15:0] last_resp_q, rd_word;
  logic [TX_W-1:0] tx_q;
  logic tx_shift;
  logic miso_q, oe_q;

  assign rd_word = (addr == WARN_ADDR_HI || addr == WARN_ADDR_LO) ? warn_q : 16'h0000;

  // in 16/17 a late stray shifts the loaded answer
  // 20-bit answer untouched by gap edges
  assign tx_shift = rise & ((state_q == ST_FRAME && !cs_s)
                   || (cs_s && (pkt_mode == PKT_16 || pkt_mode == PKT_17)));

  always_ff @(posedge mclk) begin
    if (srst) begin
      last_resp_q <= 16'h0000;
    end else if (commit && pend_ok_q && !stray && is_read) begin
      last_resp_q <= rd_word;
    end
  end

  // A dropped read replays the last valid answer
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_q <= '0;
    end else if (commit) begin
      if (pend_ok_q && !stray && is_read) begin
        tx_q <= {rd_word, {TX_PAD{1'b0}}};
      end else begin
        tx_q <= {last_resp_q, {TX_PAD{1'b0}}};
      end
    end else if (tx_shift) begin
      tx_q <= {tx_q[TX_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      miso_q <= tx_q[TX_W-1];
      oe_q <= !cs_s;
    end
  end

  assign miso = miso_q;
  assign miso_oe = oe_q;

  // ==========================================================
  // Write issue
  // late stray still writes; in 16/17 it counts into the next frame's length check
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_valid <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
    end else begin
      wr_valid <= commit && pend_ok_q && !stray && !is_read;
      if (commit) begin
        wr_addr <= addr;
        wr_data <= aligned[DATA_HI:DATA_LO];
      end
    end
  end

  // ==========================================================
  // Checks
  flag_len_a: assert property (
    @(posedge mclk) disable iff (srst) frame_end && len_bad |=> frame_err_q && !$past(clear_warn, 1) [*1] ##1 1'b1 or frame_err_q)
    else $error("edge count mismatch did not raise the frame flag");

  flag_msb_a: assert property (
    @(posedge mclk) disable iff (srst) frame_end && first_q |=> frame_err_q ##1 warn_q[FRAME_ERR_BIT])
    else $error("leading one did not reach warning bit 11");

  flag_manch_a: assert property (
    @(posedge mclk) disable iff (srst) manch_frame_err |=> frame_err_q)
    else $error("supply-line frame error not flagged");

  flag_sticky_a: assert property (
    @(posedge mclk) disable iff (srst) frame_err_q && !clear_warn |=> frame_err_q)
    else $error("frame flag dropped without clear");

  warn_map_a: assert property (
    @(posedge mclk) disable iff (srst) ##1 warn_q[15:12] == WARN_FIXED
      && !warn_q[WARN_ZERO_BIT] && warn_q[CRC_ERR_BIT] == $past(crc_err_q))
    else $error("warning word layout wrong");

  gap_count_a: assert property (
    @(posedge mclk) disable iff (srst) cs_s && !cs_rise && fall && pkt_mode == PKT_16
      && edge_cnt != CNT_MAX |=> edge_cnt == $past(edge_cnt) + CNT_W'(1))
    else $error("gap edge not counted in 16-bit mode");

  gap_hold21_a: assert property (
    @(posedge mclk) disable iff (srst) cs_s && !cs_rise && pkt_mode == PKT_21
      && $stable(pkt_mode) |=> $stable(edge_cnt))
    else $error("21-bit mode counted while deselected");

  early_drop_a: assert property (
    @(posedge mclk) disable iff (srst) commit && stray |=> !wr_valid)
    else $error("write issued despite early stray edge");

  late_write_a: assert property (
    @(posedge mclk) disable iff (srst) commit && pend_ok_q && !stray && !is_read |=> wr_valid)
    else $error("clean write not issued");

  read_keep_a: assert property (
    @(posedge mclk) disable iff (srst) commit && stray |=> $stable(last_resp_q)
      ##0 tx_q[TX_W-1 -: 16] == last_resp_q)
    else $error("dropped read altered the answer");

  crc_flag_a: assert property (
    @(posedge mclk) disable iff (srst) crc_set ##1 !crc_set [*1] |-> crc_err_q)
    else $error("checksum error not flagged");

endmodule

/* hw/sync2.sv */
module sync2 #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================
  // Two stages; only the second stage is visible
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* pkg/frame_check_pkg.sv */
package frame_check_pkg;

  // ==========================================================
  // Warning register map
  localparam logic [5:0] WARN_ADDR_HI = 6'h26;
  localparam logic [5:0] WARN_ADDR_LO = 6'h27;
  localparam logic [3:0] WARN_FIXED = 4'hB;
  localparam int FRAME_ERR_BIT = 11;
  localparam int CRC_ERR_BIT = 10;
  localparam int WARN_ZERO_BIT = 9;
  localparam int WARN_OTHER_W = 9;
  localparam logic [15:0] WARN_RESET = 16'hB000;

  // ==========================================================
  // Nonvolatile configuration location holding the 17-bit select
  localparam logic [7:0] NVM_S17_LOC = 8'h1B;
  localparam int S17_BIT = 1;

  // ==========================================================
  // Packet lengths and frame field positions (first bit on top)
  typedef enum logic [1:0] {
    PKT_16 = 2'b00,
    PKT_17 = 2'b01,
    PKT_20 = 2'b10,
    PKT_21 = 2'b11
  } pkt_mode_t;

  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_17 = 5'h11;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_21 = 5'h15;
  localparam int RX_W = 21;
  localparam logic [4:0] RX_LEN = 5'h15;
  localparam int RW_POS = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 13;
  localparam int DATA_HI = 12;
  localparam int DATA_LO = 5;
  localparam logic RW_READ = 1'b1;
  localparam int TX_W = 21;
  localparam int TX_PAD = 5;

  // ==========================================================
  // Edge counter
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // ==========================================================
  // Timing: stray-edge window after chip select rises
  localparam int CLK_MHZ = 10;
  localparam int STRAY_WIN_NS = 70;
  localparam int STRAY_WIN_RAW = STRAY_WIN_NS * CLK_MHZ / 1000;
  localparam int STRAY_WIN_CYC = (STRAY_WIN_RAW < 1) ? 1 : STRAY_WIN_RAW;
  localparam logic [3:0] HOLD_LOAD = 4'(STRAY_WIN_CYC - 1);

  // ==========================================================
  // Frame sequencing
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_HOLD = 2'b10
  } state_t;

endpackage

/* verification/spi_frame_error_detector_tb_top.sv */
module spi_frame_error_detector_tb_top
  import frame_check_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk;
  logic srst;
  logic sclk;
  logic cs_n;
  logic mosi;
  pkt_mode_t pkt_mode;
  logic [7:0] nvm_cfg_1b;
  logic crc_check_en;
  logic crc_mismatch;
  logic manch_frame_err;
  logic clear_warn;
  logic [WARN_OTHER_W-1:0] other_warn;
  logic miso;
  logic miso_oe;
  logic wr_valid;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic [15:0] warning_flags;
  int err_total = 0;
  int n_tests = 0;
  int wr_cnt = 0;
  int oe_cnt = 0;
  logic [13:0] wr_seen = '0;

  // ==========================================================
  // Clock, design and far side
  always #50 mclk = ~mclk;

  spi_frame_error_detector dut_u (
    .mclk(mclk),
    .srst(srst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .pkt_mode(pkt_mode),
    .nvm_cfg_1b(nvm_cfg_1b),
    .crc_check_en(crc_check_en),
    .crc_mismatch(crc_mismatch),
    .manch_frame_err(manch_frame_err),
    .clear_warn(clear_warn),
    .other_warn(other_warn),
    .miso(miso),
    .miso_oe(miso_oe),
    .wr_valid(wr_valid),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .warning_flags(warning_flags)
  );

  spi_master_model mst_u (
    .mclk(mclk),
    .miso(miso),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi)
  );

  // One-cycle pulse, so count it where it stands
  always @(posedge mclk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      wr_seen <= {wr_addr, wr_data};
    end
    if (miso_oe === 1'b1) begin
      oe_cnt++;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic int mlen(input pkt_mode_t m);
    case (m)
      PKT_16: return 16;
      PKT_17: return 17;
      PKT_20: return 20;
      default: return 21;
    endcase
  endfunction

  task automatic clr();
    @(negedge mclk);
    clear_warn = 1'b1;
    @(negedge mclk);
    clear_warn = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // Flush with a clean read so the counter starts fresh in the new mode
  task automatic setup(input pkt_mode_t m, input logic s17);
    @(negedge mclk);
    pkt_mode = m;
    nvm_cfg_1b = {6'h00, s17, 1'b0};
    mst_u.frame(21'(1) << (mlen(m) - 2), mlen(m));
    clr();
  endtask

  task automatic run(input pkt_mode_t m, input logic s17, input int ns, input int n,
                     input logic [20:0] bits, input logic exp);
    setup(m, s17);
    mst_u.stray(ns, 20);
    mst_u.frame(bits, n);
    check(21'(warning_flags[FRAME_ERR_BIT]), 21'(exp));
  endtask

  // ==========================================================
  // Watchdog, well past the expected run
  initial begin
    #5000000;
    err_total++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    pkt_mode = PKT_16;
    nvm_cfg_1b = 8'h00;
    crc_check_en = 1'b0;
    crc_mismatch = 1'b0;
    manch_frame_err = 1'b0;
    clear_warn = 1'b0;
    other_warn = 9'h0A5;
    repeat (5) @(negedge mclk);
    srst = 1'b0;
    repeat (2) @(negedge mclk);
    check(21'(warning_flags), 21'({4'hB, 3'b000, 9'h0A5}));
    check(21'(miso_oe), 21'd0);
    clr();
    run(PKT_16, 1'b0, 0, 16, 21'h04000, 1'b0);
    run(PKT_16, 1'b0, 0, 15, 21'h02000, 1'b1);
    run(PKT_16, 1'b0, 1, 16, 21'h04000, 1'b1);
    run(PKT_16, 1'b1, 2, 16, 21'h04000, 1'b1);
    run(PKT_16, 1'b1, 0, 17, 21'h08000, 1'b0);
    run(PKT_17, 1'b1, 0, 17, 21'h08000, 1'b0);
    run(PKT_17, 1'b1, 1, 17, 21'h08000, 1'b1);
    run(PKT_20, 1'b0, 1, 20, 21'h40000, 1'b0);
    run(PKT_21, 1'b0, 3, 21, 21'h80000, 1'b0);
    // Write followed by a late stray edge
    setup(PKT_16, 1'b0);
    mst_u.frame(21'h0125A, 16);
    mst_u.stray(1, 20);
    check(21'(wr_cnt), 21'd1);
    check(21'(wr_seen), 21'({6'h12, 8'h5A}));
    mst_u.frame(21'h04000, 16);
    check(21'(warning_flags[FRAME_ERR_BIT]), 21'd1);
    run(PKT_16, 1'b0, 0, 16, 21'h0925A, 1'b1);
    check(21'(wr_cnt), 21'd1);
    // Write cut by a clock drop at the select edge
    setup(PKT_16, 1'b0);
    mst_u.cut_frame(21'h0133C, 16);
    check(21'(wr_cnt), 21'd1);
    check(21'(wr_seen), 21'({6'h12, 8'h5A}));
    // Read cut the same way replays the last valid answer
    setup(PKT_20, 1'b0);
    mst_u.frame(21'h66000, 20);
    mst_u.cut_frame(21'h40000, 20);
    mst_u.frame(21'h40000, 20);
    check(21'(mst_u.rx_word[19:4]), 21'h0B0A5);
    check(21'(oe_cnt != 0), 21'd1);
    // Supply-line error, checksum error, then read back the word
    setup(PKT_16, 1'b0);
    manch_frame_err = 1'b1;
    @(negedge mclk);
    manch_frame_err = 1'b0;
    repeat (3) @(negedge mclk);
    check(21'(warning_flags[FRAME_ERR_BIT]), 21'd1);
    crc_check_en = 1'b1;
    crc_mismatch = 1'b1;
    // Checksum field exists only in 20/21-bit frames
    pkt_mode = PKT_20;
    mst_u.frame(21'h40000, 20);
    crc_mismatch = 1'b0;
    pkt_mode = PKT_16;
    check(21'(warning_flags[CRC_ERR_BIT]), 21'd1);
    mst_u.frame(21'h06600, 16);
    mst_u.frame(21'h04000, 16);
    check(21'(mst_u.rx_word[15:0]), 21'({4'hB, 3'b110, 9'h0A5}));
    check(21'(warning_flags), 21'({4'hB, 3'b110, 9'h0A5}));
    clr();
    check(21'(warning_flags), 21'({4'hB, 3'b000, 9'h0A5}));
    crc_check_en = 1'b0;
    tally_and_finish();
  end
endmodule

/* verification/spi_master_model.sv */
module spi_master_model (
  input wire logic mclk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [20:0] rx_word;
  logic early_stray = 1'b0;

  // ==========================================================
  // Idle line levels
  // clock high deselected
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
    rx_word = '0;
  end

  // Half of the 800 ns serial clock period
  task automatic half();
    repeat (4) @(negedge mclk);
  endtask

  // ==========================================================
  // Mode 3 frame, MSB first, miso taken just before each rise
  task automatic frame(input logic [20:0] bits, input int n);
    cs_n = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = bits[i];
      half();
      rx_word = {rx_word[19:0], miso};
      sclk = 1'b1;
      half();
    end
    cs_n = 1'b1;
    // Cut frame: clock drops together with the select edge
    if (early_stray) begin
      sclk = 1'b0;
    end
    // Released line: no pull, so show the inverse, not a stale bit
    mosi = ~mosi;
    half();
    sclk = 1'b1;
    half();
  endtask

  // Frame whose select edge meets a stray clock drop
  task automatic cut_frame(input logic [20:0] bits, input int n);
    early_stray = 1'b1;
    frame(bits, n);
    early_stray = 1'b0;
  endtask

  // ==========================================================
  // Shared-clock traffic seen while deselected
  // broken only on command
  task automatic stray(input int n, input int lead);
    repeat (lead) @(negedge mclk);
    repeat (n) begin
      sclk = 1'b0;
      half();
      sclk = 1'b1;
      half();
    end
  endtask
endmodule
